//--- dv/cbt_bus_node.sv
module cbt_bus_node
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [7:0] pattern,
    input wire logic [7:0] bit_len,
    output logic rx_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    logic [7:0] cnt;
    logic [3:0] bits;
    // idle bus floats recessive, so the line rests at 1 outside frames
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_pin <= 1'b1;
            bits <= 4'h0;
            cnt <= 8'h00;
            sh <= 8'hff;
        end
        else if (go && bits == 4'h0)
        begin
            sh <= pattern;
            bits <= 4'h8;
            cnt <= 8'h00;
            rx_pin <= pattern[7];
        end
        else if (bits != 4'h0)
        begin
            if (cnt == bit_len - 8'h01)
            begin
                cnt <= 8'h00;
                bits <= bits - 4'h1;
                sh <= {sh[6:0], 1'b1};
                rx_pin <= (bits == 4'h1) ? 1'b1 : sh[6];
            end
            else
                cnt <= cnt + 8'h01;
        end
    end
endmodule

//--- dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, clk_en = 1, hsel = 0, hwrite = 0, nd_go = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h00014c35;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, rx_pin, rx_bit, sample_pulse, tx_point, overload;
    logic sleep_ack, irq_wake, irq_err, irq_rx;
    logic [7:0] nd_pat = 0, b = 0;
    logic [8:0] rc, tc;
    cbt_pkg::cbt_engine_t eng = '0;
    int fail_count = 0, check_count = 0, n;
    always #25 clk = ~clk;
    cbt_core cbt_core_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .eng(eng), .rx_pin(rx_pin), .rx_bit(rx_bit), .sample_pulse(sample_pulse),
        .tx_point(tx_point), .overload(overload), .sleep_ack(sleep_ack),
        .irq_wake(irq_wake), .irq_err(irq_err), .irq_rx(irq_rx));
    cbt_bus_node cbt_bus_node_i (.clk(clk), .rst_n(rst_n), .go(nd_go),
        .pattern(nd_pat), .bit_len(8'h14), .rx_pin(rx_pin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_err(input logic [8:0] r, input logic [8:0] t);
        logic [7:0] f;
        f = 8'h00;
        f[cbt_pkg::RF_RXWRN] = r >= 9'h060 && r <= 9'h07f;
        f[cbt_pkg::RF_TXWRN] = t >= 9'h060 && t <= 9'h07f;
        f[cbt_pkg::RF_RXPAS] = r > 9'h07f;
        f[cbt_pkg::RF_TXPAS] = t > 9'h07f;
        f[cbt_pkg::RF_BOFF] = t > 9'h0ff;
        return {24'h0, f};
    endfunction
    task automatic end_sim();
        if (fail_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] e);
        check_count++;
        if (seen !== e)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, e);
        end
    endtask
    // one whole-word transfer; address phase held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(0, a, 0, r);
        chk(r, e);
    endtask
    task automatic ev(input logic ovr, input logic rxd, input logic [2:0] ab);
        eng.overrun <= ovr;
        eng.rx_msg_done <= rxd;
        eng.abort_done <= ab;
        @(posedge clk);
        eng.overrun <= 0;
        eng.rx_msg_done <= 0;
        eng.abort_done <= 3'h0;
        #1;
    endtask
    task automatic span(input logic txp, output int k);
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (!(txp ? tx_point : sample_pulse));
    endtask
    // timing fields only land under soft reset, so enter it, program, leave
    task automatic cfg(input logic v, input logic [3:0] s1, input logic [2:0] s2,
        input logic [5:0] p);
        b = {v, s2, s1};
        wr(cbt_pkg::ADDR_CTRL, 32'h1);
        wr(cbt_pkg::ADDR_CTRL, {18'h0, p, 8'h01});
        wr(cbt_pkg::ADDR_BTR1, {24'h0, b});
        rd(cbt_pkg::ADDR_BTR1, {24'h0, b});
        wr(cbt_pkg::ADDR_CTRL, {18'h0, p, 8'h00});
        rd(cbt_pkg::ADDR_CTRL, {18'h0, p, 8'h00});
        wr(cbt_pkg::ADDR_BTR1, {24'h0, ~b});
        rd(cbt_pkg::ADDR_BTR1, {24'h0, b});
    endtask
    initial
    begin
        repeat (2000000 / 50) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial
    begin
        eng.tx_empty = 3'h7;
        repeat (16) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk({31'h0, hresp}, 0);
        rd(cbt_pkg::ADDR_BTR1, 0);
        rd(cbt_pkg::ADDR_RFLG, 0);
        rd(cbt_pkg::ADDR_TFLG, 0);
        rd(cbt_pkg::ADDR_CTRL, 32'h1);
        rd(8'h20, 0);
        wr(cbt_pkg::ADDR_RIER, 32'hff);
        rd(cbt_pkg::ADDR_RIER, 0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(lfsr(seed));
            cfg(seed[10], (i == 0) ? 4'hf : seed[3:0] | 4'h1,
                (i == 0) ? 3'h7 : seed[6:4], {4'h0, seed[9:8]});
            span(1, n);
            span(1, n);
            chk(n, (seed[9:8] + 1) * (b[3:0] + b[6:4] + 3));
            span(0, n);
            span(1, n);
            chk(n, (seed[9:8] + 1) * (b[6:4] + 1));
        end
        for (int v = 0; v < 2; v++)
        begin
            cfg(v[0], 4'h5, 3'h2, 6'h01);
            seed = lfsr(seed);
            span(1, n);
            nd_pat <= {1'b0, seed[6:0]};
            nd_go <= 1;
            @(posedge clk);
            nd_go <= 0;
            for (int k = 7; k >= 0; k--)
            begin
                span(0, n);
                @(posedge clk);
                #1;
                chk(rx_bit, nd_pat[k]);
            end
        end
        wr(cbt_pkg::ADDR_RIER, 32'hff);
        rd(cbt_pkg::ADDR_RIER, 32'hff);
        ev(1, 0, 0);
        chk(irq_err, 1);
        rd(cbt_pkg::ADDR_RFLG, 32'h02);
        wr(cbt_pkg::ADDR_RFLG, 0);
        rd(cbt_pkg::ADDR_RFLG, 32'h02);
        wr(cbt_pkg::ADDR_RFLG, 32'h02);
        rd(cbt_pkg::ADDR_RFLG, 0);
        chk(irq_err, 0);
        wr(cbt_pkg::ADDR_RIER, 32'hfd);
        ev(1, 0, 0);
        @(posedge clk);
        #1;
        chk(irq_err, 0);
        wr(cbt_pkg::ADDR_RFLG, 32'h02);
        wr(cbt_pkg::ADDR_RIER, 32'hff);
        // an event that falls while the clock enable is low must leave no trace
        clk_en <= 0;
        ev(1, 0, 0);
        chk(irq_err, 0);
        clk_en <= 1;
        rd(cbt_pkg::ADDR_RFLG, 0);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(lfsr(seed));
            rc = (i == 0) ? 9'h060 : (i == 1) ? 9'h080 : seed[8:0];
            tc = (i == 0) ? 9'h100 : (i == 1) ? 9'h07f : seed[20:12];
            eng.rx_err_count <= rc;
            eng.tx_err_count <= tc;
            repeat (3) @(posedge clk);
            rd(cbt_pkg::ADDR_RFLG, exp_err(rc, tc));
            chk(irq_err, exp_err(rc, tc) != 0);
            wr(cbt_pkg::ADDR_RFLG, 32'hff);
            rd(cbt_pkg::ADDR_RFLG, exp_err(rc, tc));
            eng.rx_err_count <= 0;
            eng.tx_err_count <= 0;
            repeat (2) @(posedge clk);
            wr(cbt_pkg::ADDR_RFLG, 32'hff);
            rd(cbt_pkg::ADDR_RFLG, 0);
        end
        ev(0, 1, 0);
        chk(irq_rx, 1);
        rd(cbt_pkg::ADDR_RFLG, 32'h01);
        ev(0, 1, 0);
        chk(overload, 1);
        wr(cbt_pkg::ADDR_RFLG, 32'h01);
        rd(cbt_pkg::ADDR_RFLG, 0);
        chk(irq_rx, 0);
        for (int k = 0; k < 3; k++)
        begin
            ev(0, 0, 3'h1 << k);
            rd(cbt_pkg::ADDR_TFLG, 32'h1 << k);
            eng.tx_empty[k] <= 0;
            repeat (2) @(posedge clk);
            rd(cbt_pkg::ADDR_TFLG, 0);
            eng.tx_empty[k] <= 1;
            ev(0, 0, 3'h1 << k);
            wr(cbt_pkg::ADDR_TFLG, 32'h1 << k);
            rd(cbt_pkg::ADDR_TFLG, 0);
        end
        wr(cbt_pkg::ADDR_CTRL, 32'h2);
        n = 0;
        while (!sleep_ack && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(sleep_ack, 1);
        eng.bus_activity <= 1;
        n = 0;
        while (sleep_ack && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(sleep_ack, 0);
        repeat (2) @(posedge clk);
        #1;
        chk(irq_wake, 1);
        wr(cbt_pkg::ADDR_CTRL, 0);
        eng.bus_activity <= 0;
        wr(cbt_pkg::ADDR_RFLG, 32'h80);
        rd(cbt_pkg::ADDR_RFLG, 0);
        chk(irq_wake, 0);
        ev(1, 0, 3'h7);
        wr(cbt_pkg::ADDR_CTRL, 32'h1);
        rd(cbt_pkg::ADDR_RFLG, 0);
        rd(cbt_pkg::ADDR_RIER, 0);
        rd(cbt_pkg::ADDR_TFLG, 0);
        ev(1, 1, 3'h7);
        rd(cbt_pkg::ADDR_RFLG, 0);
        rd(cbt_pkg::ADDR_TFLG, 0);
        // idle bus leaves the last sample recessive; soft reset parks timing in its window
        rd(cbt_pkg::ADDR_STAT, 32'h6);
        end_sim();
    end
endmodule

//--- rtl/cbt_core.sv
// Operation
// - vote select set and segment one field 2 or more: majority of three samples; otherwise: single sample
// - sample point is the last of three samples; receivers sample there
// - segment one field is value plus one quanta; segment two likewise
// - segment lengths set quanta per bit and sample point position
// - transmit point starts each bit that ends by count, not one cut short by an edge in segment two; edges in resync window resynchronise
// - bit timing writes only land while soft reset is set
// - write one clears a flag, write zero keeps it, reads show flags
// - clearing a receiver flag fails while its cause still holds
// - hard or soft reset clears and holds flags and enables
// - bus activity in sleep clears sleep ack and sets wake flag in the same cycle
// - receive warning flag set on entering count 96 to 127
// - transmit warning flag set on entering count 96 to 127
// - receive passive flag set when receive count exceeds 127
// - transmit passive flag set when transmit count exceeds 127
// - bus off flag set when transmit count exceeds 255
// - overrun flag set on receive buffer overrun
// - receive full set on good message; software reads then clears
// - while receive full, no buffer swap, overload signalled instead
// - each receiver flag gated by its own enable onto its interrupt line; abort acknowledge flags drive no interrupt
// - one abort acknowledge flag per transmit buffer, set on abort
// - abort acknowledge clears when buffer empty flag returns to zero
// - soft reset drops bus synchronisation; error counts are kept
// - prescaler divides module clock by value plus one
module cbt_core
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cbt_pkg::cbt_engine_t eng,
    input wire logic rx_pin,
    output logic rx_bit,
    output logic sample_pulse,
    output logic tx_point,
    output logic overload,
    output logic sleep_ack,
    output logic irq_wake,
    output logic irq_err,
    output logic irq_rx
);
    cbt_pkg::cbt_state_t s;
    cbt_pkg::cbt_state_t next_s;

    function automatic logic in_warn(input logic [8:0] c);
        in_warn = (c >= cbt_pkg::WARN_LOW) && (c <= cbt_pkg::PASSIVE_LIMIT);
    endfunction

    function automatic logic [31:0] rd_mux(input cbt_pkg::cbt_state_t q, input logic [7:0] a);
        case (a)
            cbt_pkg::ADDR_BTR1: rd_mux = {24'h000000, q.btr1};
            cbt_pkg::ADDR_RFLG: rd_mux = {24'h000000, q.rflg};
            cbt_pkg::ADDR_RIER: rd_mux = {24'h000000, q.rier};
            cbt_pkg::ADDR_TFLG: rd_mux = {29'h00000000, q.tflg};
            cbt_pkg::ADDR_CTRL: rd_mux = {18'h00000, q.presc, 6'h00, q.sleep_req, q.soft_reset};
            cbt_pkg::ADDR_STAT: rd_mux = {28'h0000000, q.overload, q.rx_bit, q.phase == cbt_pkg::PH_SYNC, q.sleep_ack};
            default: rd_mux = 32'h00000000;
        endcase
    endfunction

    logic [3:0] seg1_len;
    logic [3:0] seg2_len;
    logic [7:0] rcond;
    logic [7:0] wdata;
    logic wr_now;
    logic tq_tick;
    logic edge_seen;
    logic voted;

    always_comb
    begin
        next_s = s;
        wdata = hwdata[7:0];
        wr_now = s.bus_wr;
        seg1_len = s.btr1[cbt_pkg::BTR1_SEG1_LSB +: 4];
        seg2_len = {1'b0, s.btr1[cbt_pkg::BTR1_SEG2_LSB +: 3]};
        tq_tick = (s.presc_cnt == s.presc);
        edge_seen = s.prev_rx && !rx_pin;
        voted = (s.early[0] & s.early[1]) | (s.early[0] & rx_pin) | (s.early[1] & rx_pin);
        // conditions that still hold block a write-one clear
        rcond = 8'h00;
        rcond[cbt_pkg::RF_RXWRN] = in_warn(eng.rx_err_count);
        rcond[cbt_pkg::RF_TXWRN] = in_warn(eng.tx_err_count);
        rcond[cbt_pkg::RF_RXPAS] = eng.rx_err_count > cbt_pkg::PASSIVE_LIMIT;
        rcond[cbt_pkg::RF_TXPAS] = eng.tx_err_count > cbt_pkg::PASSIVE_LIMIT;
        rcond[cbt_pkg::RF_BOFF] = eng.tx_err_count > cbt_pkg::BUSOFF_LIMIT;
        rcond[cbt_pkg::RF_OVR] = eng.overrun;
        rcond[cbt_pkg::RF_RXF] = eng.rx_msg_done;
        rcond[cbt_pkg::RF_WAKE] = eng.bus_activity && s.sleep_ack;

        // AHB-Lite: capture address phase, act in data phase, zero wait
        next_s.bus_wr = hsel && hready && htrans[1] && hwrite;
        next_s.bus_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            next_s.hrdata = rd_mux(s, haddr[7:0]);
        end

        next_s.sample_pulse = 1'b0;
        next_s.tx_point = 1'b0;
        next_s.prev_rx = rx_pin;
        next_s.presc_cnt = tq_tick ? 6'h00 : s.presc_cnt + 6'h01;

        // bit timing state machine, one quantum per step
        if (tq_tick)
        begin
            case (s.phase)
                cbt_pkg::PH_SYNC:
                begin
                    next_s.phase = cbt_pkg::PH_SEG1;
                    next_s.tq_cnt = 4'h0;
                end
                cbt_pkg::PH_SEG1:
                begin
                    if (s.btr1[cbt_pkg::BTR1_VOTE_BIT] && seg1_len >= 4'h2
                        && s.tq_cnt >= seg1_len - 4'h2)
                    begin
                        next_s.early = {s.early[0], rx_pin};
                    end
                    if (edge_seen)
                    begin
                        next_s.tq_cnt = 4'h0; // hard sync when edge lands in segment one
                    end
                    else if (s.tq_cnt == seg1_len)
                    begin
                        next_s.phase = cbt_pkg::PH_SEG2;
                        next_s.tq_cnt = 4'h0;
                        next_s.sample_pulse = 1'b1;
                        next_s.rx_bit = (s.btr1[cbt_pkg::BTR1_VOTE_BIT] && seg1_len >= 4'h2)
                            ? voted : rx_pin;
                    end
                    else
                    begin
                        next_s.tq_cnt = s.tq_cnt + 4'h1;
                    end
                end
                cbt_pkg::PH_SEG2:
                begin
                    if (s.tq_cnt == seg2_len)
                    begin
                        next_s.phase = cbt_pkg::PH_SYNC;
                        next_s.tx_point = 1'b1;
                        next_s.tq_cnt = 4'h0;
                    end
                    else
                    begin
                        next_s.tq_cnt = s.tq_cnt + 4'h1;
                    end
                end
                default:
                begin
                    next_s.phase = cbt_pkg::PH_SYNC;
                end
            endcase
        end
        if (edge_seen && s.phase == cbt_pkg::PH_SEG2)
        begin
            next_s.phase = cbt_pkg::PH_SYNC;
            next_s.tq_cnt = 4'h0;
            next_s.presc_cnt = 6'h00;
        end

        // sleep handshake
        if (s.sleep_req && !eng.bus_activity)
        begin
            next_s.sleep_ack = 1'b1;
        end
        if (!s.sleep_req)
        begin
            next_s.sleep_ack = 1'b0;
        end
        if (s.sleep_ack && eng.bus_activity)
        begin
            next_s.sleep_ack = 1'b0;
        end

        // write-one clear, blocked while the cause holds
        if (wr_now && s.bus_addr == cbt_pkg::ADDR_RFLG)
        begin
            next_s.rflg = s.rflg & ~(wdata & ~rcond);
        end
        if (wr_now && s.bus_addr == cbt_pkg::ADDR_TFLG)
        begin
            next_s.tflg = s.tflg & ~wdata[2:0];
        end
        if (wr_now && s.bus_addr == cbt_pkg::ADDR_RIER)
        begin
            next_s.rier = wdata;
        end
        if (wr_now && s.bus_addr == cbt_pkg::ADDR_BTR1 && s.soft_reset)
        begin
            next_s.btr1 = wdata;
        end
        if (wr_now && s.bus_addr == cbt_pkg::ADDR_CTRL)
        begin
            next_s.soft_reset = hwdata[cbt_pkg::CTRL_SOFT_RESET];
            next_s.sleep_req = hwdata[cbt_pkg::CTRL_SLEEP_REQ];
            if (s.soft_reset)
            begin
                next_s.presc = hwdata[cbt_pkg::CTRL_PRESC_LSB +: 6];
            end
        end

        // flag sets win over a clear in the same cycle
        next_s.rx_wrn_prev = rcond[cbt_pkg::RF_RXWRN];
        next_s.tx_wrn_prev = rcond[cbt_pkg::RF_TXWRN];
        next_s.rx_pas_prev = rcond[cbt_pkg::RF_RXPAS];
        next_s.tx_pas_prev = rcond[cbt_pkg::RF_TXPAS];
        next_s.boff_prev = rcond[cbt_pkg::RF_BOFF];
        if (s.sleep_ack && eng.bus_activity)
        begin
            next_s.rflg[cbt_pkg::RF_WAKE] = 1'b1;
        end
        if (rcond[cbt_pkg::RF_RXWRN] && !s.rx_wrn_prev)
        begin
            next_s.rflg[cbt_pkg::RF_RXWRN] = 1'b1;
        end
        if (rcond[cbt_pkg::RF_TXWRN] && !s.tx_wrn_prev)
        begin
            next_s.rflg[cbt_pkg::RF_TXWRN] = 1'b1;
        end
        if (rcond[cbt_pkg::RF_RXPAS] && !s.rx_pas_prev)
        begin
            next_s.rflg[cbt_pkg::RF_RXPAS] = 1'b1;
        end
        if (rcond[cbt_pkg::RF_TXPAS] && !s.tx_pas_prev)
        begin
            next_s.rflg[cbt_pkg::RF_TXPAS] = 1'b1;
        end
        if (rcond[cbt_pkg::RF_BOFF] && !s.boff_prev)
        begin
            next_s.rflg[cbt_pkg::RF_BOFF] = 1'b1;
        end
        if (eng.overrun)
        begin
            next_s.rflg[cbt_pkg::RF_OVR] = 1'b1;
        end
        next_s.overload = 1'b0;
        if (eng.rx_msg_done)
        begin
            if (s.rflg[cbt_pkg::RF_RXF])
            begin
                next_s.overload = 1'b1;
            end
            else
            begin
                next_s.rflg[cbt_pkg::RF_RXF] = 1'b1;
            end
        end
        next_s.prev_tx_empty = eng.tx_empty;
        for (int i = 0; i < 3; i++)
        begin
            if (s.prev_tx_empty[i] && !eng.tx_empty[i])
            begin
                next_s.tflg[i] = 1'b0;
            end
            if (eng.abort_done[i])
            begin
                next_s.tflg[i] = 1'b1;
            end
        end

        next_s.irq_wake = next_s.rflg[cbt_pkg::RF_WAKE] & next_s.rier[cbt_pkg::RF_WAKE];
        next_s.irq_err = |(next_s.rflg[6:1] & next_s.rier[6:1]);
        next_s.irq_rx = next_s.rflg[cbt_pkg::RF_RXF] & next_s.rier[cbt_pkg::RF_RXF];

        // soft reset holds flags, enables and sync lost; counts live outside
        if (next_s.soft_reset)
        begin
            next_s.rflg = cbt_pkg::FLAG_RESET;
            next_s.rier = cbt_pkg::FLAG_RESET;
            next_s.tflg = 3'h0;
            next_s.phase = cbt_pkg::PH_SYNC;
            next_s.tq_cnt = 4'h0;
            next_s.presc_cnt = 6'h00;
            next_s.sample_pulse = 1'b0;
            next_s.tx_point = 1'b0;
            next_s.overload = 1'b0;
            next_s.irq_wake = 1'b0;
            next_s.irq_err = 1'b0;
            next_s.irq_rx = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.btr1 <= cbt_pkg::BTR1_RESET;
            s.soft_reset <= cbt_pkg::CTRL_RESET[0];
            s.presc <= cbt_pkg::PRESC_RESET;
            s.phase <= cbt_pkg::PH_SYNC;
            s.rx_bit <= 1'b1;
            s.prev_rx <= 1'b1;
        end
        else if (clk_en)
        begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rx_bit = s.rx_bit;
    assign sample_pulse = s.sample_pulse;
    assign tx_point = s.tx_point;
    assign overload = s.overload;
    assign sleep_ack = s.sleep_ack;
    assign irq_wake = s.irq_wake;
    assign irq_err = s.irq_err;
    assign irq_rx = s.irq_rx;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    btr_lock_a: assert property (clk_en && !s.soft_reset |=> $stable(s.btr1))
        else $error("bit timing changed outside soft reset");
    soft_hold_a: assert property (s.soft_reset |-> s.rflg == 8'h00 && s.rier == 8'h00)
        else $error("flags not held in soft reset");
    rxf_set_a: assert property (clk_en && eng.rx_msg_done && !s.soft_reset && !next_s.soft_reset
        |=> s.rflg[cbt_pkg::RF_RXF])
        else $error("receive full not set");
    ovl_a: assert property (clk_en && eng.rx_msg_done && s.rflg[cbt_pkg::RF_RXF]
        && !next_s.soft_reset |=> overload)
        else $error("overload not signalled");
    err_irq_a: assert property (irq_err == |(s.rflg[6:1] & s.rier[6:1]))
        else $error("error line mismatch");
    w1c_hold_a: assert property (clk_en && !s.soft_reset && eng.overrun && !next_s.soft_reset
        |=> s.rflg[cbt_pkg::RF_OVR])
        else $error("overrun flag lost");
    abort_set_a: assert property (clk_en && eng.abort_done[0] && !next_s.soft_reset |=> s.tflg[0])
        else $error("abort ack not set");
    wake_seq_a: assert property (clk_en && s.sleep_ack && eng.bus_activity && !next_s.soft_reset
        |=> !sleep_ack && s.rflg[cbt_pkg::RF_WAKE])
        else $error("wake sequence wrong");
    seg_sample_a: assert property (sample_pulse |-> s.phase == cbt_pkg::PH_SEG2)
        else $error("sample outside segment boundary");

    rxf_c: cover property (eng.rx_msg_done ##1 s.rflg[cbt_pkg::RF_RXF]);
    ovl_c: cover property (overload);
    wake_c: cover property (irq_wake);
    bit_c: cover property (sample_pulse ##[1:300] tx_point);
endmodule

//--- rtl/cbt_pkg.sv
package cbt_pkg;

    // register byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_BTR1 = 8'h00;
    localparam logic [7:0] ADDR_RFLG = 8'h04;
    localparam logic [7:0] ADDR_RIER = 8'h08;
    localparam logic [7:0] ADDR_TFLG = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // bit_timing_second field positions
    localparam int BTR1_VOTE_BIT = 7;
    localparam int BTR1_SEG2_LSB = 4;
    localparam int BTR1_SEG1_LSB = 0;

    // receiver flag / enable bit positions
    localparam int RF_WAKE = 7;
    localparam int RF_RXWRN = 6;
    localparam int RF_TXWRN = 5;
    localparam int RF_RXPAS = 4;
    localparam int RF_TXPAS = 3;
    localparam int RF_BOFF = 2;
    localparam int RF_OVR = 1;
    localparam int RF_RXF = 0;

    // control register bit positions
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_SLEEP_REQ = 1;
    localparam int CTRL_PRESC_LSB = 8;

    // reset values
    localparam logic [7:0] BTR1_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [5:0] PRESC_RESET = 6'h00;

    // error count thresholds
    localparam logic [8:0] WARN_LOW = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0ff;

    // bit-timing phases, one-hot
    typedef enum logic [2:0]
    {
        PH_SYNC = 3'b001,
        PH_SEG1 = 3'b010,
        PH_SEG2 = 3'b100
    } cbt_phase_t;

    // events from the protocol engine
    typedef struct packed
    {
        logic [8:0] rx_err_count;
        logic [8:0] tx_err_count;
        logic bus_activity;
        logic overrun;
        logic rx_msg_done;
        logic [2:0] abort_done;
        logic [2:0] tx_empty;
    } cbt_engine_t;

    typedef struct packed
    {
        logic [7:0] btr1;
        logic [7:0] rflg;
        logic [7:0] rier;
        logic [2:0] tflg;
        logic soft_reset;
        logic sleep_req;
        logic sleep_ack;
        logic [5:0] presc;
        logic [5:0] presc_cnt;
        cbt_phase_t phase;
        logic [3:0] tq_cnt;
        logic [1:0] early;
        logic rx_bit;
        logic sample_pulse;
        logic tx_point;
        logic prev_rx;
        logic [2:0] prev_tx_empty;
        logic rx_wrn_prev;
        logic tx_wrn_prev;
        logic rx_pas_prev;
        logic tx_pas_prev;
        logic boff_prev;
        logic overload;
        logic irq_wake;
        logic irq_err;
        logic irq_rx;
        logic [31:0] hrdata;
        logic bus_wr;
        logic [7:0] bus_addr;
    } cbt_state_t;

endpackage
